/* include/stap_pkg.sv */
// Shared constants and types of the memory test access port.
package stap_pkg;

    // ==========================================================
    // Scan path lengths and identification field widths
    localparam int IR_W   = 3;
    localparam int ID_W   = 32;
    localparam int BSR_W  = 107;
    localparam int REV_W  = 3;
    localparam int PART_W = 17;
    localparam int MFR_W  = 11;

    // ==========================================================
    // Identification field positions
    localparam int ID_REV_LSB  = 29;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MFR_LSB  = 1;

    // ==========================================================
    // Instruction codes
    localparam logic [IR_W-1:0] INS_EXTEST  = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE  = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLEZ = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE  = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS  = 3'h7;

    // ==========================================================
    // Capture patterns and reset values
    localparam logic [IR_W-1:0]  IR_CAPTURE = 3'h1;
    localparam int               BUS_EN_BIT = 47;
    localparam logic [BSR_W-1:0] BSR_RESET  = 107'h8000_0000_0000;

    // ==========================================================
    // Controller states
    typedef enum logic [15:0] {
        ST_TLR   = 16'h0001,
        ST_RTI   = 16'h0002,
        ST_SELDR = 16'h0004,
        ST_CAPDR = 16'h0008,
        ST_SHDR  = 16'h0010,
        ST_EX1DR = 16'h0020,
        ST_PADR  = 16'h0040,
        ST_EX2DR = 16'h0080,
        ST_UPDR  = 16'h0100,
        ST_SELIR = 16'h0200,
        ST_CAPIR = 16'h0400,
        ST_SHIR  = 16'h0800,
        ST_EX1IR = 16'h1000,
        ST_PAIR  = 16'h2000,
        ST_EX2IR = 16'h4000,
        ST_UPIR  = 16'h8000
    } stap_state_type;

endpackage

/* include/stap_ctl_if.sv */
// Link between the port core and its controller state machine.
`timescale 1ns/1ps
interface stap_ctl_if;
    logic                     tckRise;
    logic                     tms;
    stap_pkg::stap_state_type state;

    modport fsm  (input tckRise, input tms, output state);
    modport core (output tckRise, output tms, input state);
endinterface

/* verilog/stap_fsm.sv */
// Sixteen-state test controller, stepped on each test clock rise.
`timescale 1ns/1ps
module stap_fsm
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Controller link
    stap_ctl_if.fsm  ctl
);

    // ==========================================================
    // Next state
    function automatic stap_pkg::stap_state_type nextState(
        input stap_pkg::stap_state_type cur,
        input logic                     m);
        stap_pkg::stap_state_type n;
        n = stap_pkg::ST_TLR;
        unique case (cur)
            stap_pkg::ST_TLR:   n = m ? stap_pkg::ST_TLR   : stap_pkg::ST_RTI;
            stap_pkg::ST_RTI:   n = m ? stap_pkg::ST_SELDR : stap_pkg::ST_RTI;
            stap_pkg::ST_SELDR: n = m ? stap_pkg::ST_SELIR : stap_pkg::ST_CAPDR;
            stap_pkg::ST_CAPDR: n = m ? stap_pkg::ST_EX1DR : stap_pkg::ST_SHDR;
            stap_pkg::ST_SHDR:  n = m ? stap_pkg::ST_EX1DR : stap_pkg::ST_SHDR;
            stap_pkg::ST_EX1DR: n = m ? stap_pkg::ST_UPDR  : stap_pkg::ST_PADR;
            stap_pkg::ST_PADR:  n = m ? stap_pkg::ST_EX2DR : stap_pkg::ST_PADR;
            stap_pkg::ST_EX2DR: n = m ? stap_pkg::ST_UPDR  : stap_pkg::ST_SHDR;
            stap_pkg::ST_UPDR:  n = m ? stap_pkg::ST_SELDR : stap_pkg::ST_RTI;
            stap_pkg::ST_SELIR: n = m ? stap_pkg::ST_TLR   : stap_pkg::ST_CAPIR;
            stap_pkg::ST_CAPIR: n = m ? stap_pkg::ST_EX1IR : stap_pkg::ST_SHIR;
            stap_pkg::ST_SHIR:  n = m ? stap_pkg::ST_EX1IR : stap_pkg::ST_SHIR;
            stap_pkg::ST_EX1IR: n = m ? stap_pkg::ST_UPIR  : stap_pkg::ST_PAIR;
            stap_pkg::ST_PAIR:  n = m ? stap_pkg::ST_EX2IR : stap_pkg::ST_PAIR;
            stap_pkg::ST_EX2IR: n = m ? stap_pkg::ST_UPIR  : stap_pkg::ST_SHIR;
            stap_pkg::ST_UPIR:  n = m ? stap_pkg::ST_SELDR : stap_pkg::ST_RTI;
            default:            n = stap_pkg::ST_TLR;
        endcase
        return n;
    endfunction

    stap_pkg::stap_state_type state_ff;
    stap_pkg::stap_state_type nxt_state;

    assign nxt_state = nextState(state_ff, ctl.tms);
    assign ctl.state = state_ff;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            state_ff <= stap_pkg::ST_TLR;
        else if (ctl.tckRise)
            state_ff <= nxt_state; // R15
    end

    // ==========================================================
    // Checks
    chk_tlr_hold_high: assert property (@(posedge ref_clk) disable iff (!rstn) // R15
        state_ff == stap_pkg::ST_TLR && ctl.tckRise && ctl.tms |=> state_ff == stap_pkg::ST_TLR)
        else $error("Test-logic-reset left with mode select high.");

    chk_capir_to_shift: assert property (@(posedge ref_clk) disable iff (!rstn) // R15
        state_ff == stap_pkg::ST_CAPIR && ctl.tckRise && !ctl.tms
        |=> state_ff == stap_pkg::ST_SHIR)
        else $error("Capture-IR did not step to Shift-IR.");

    chk_state_still: assert property (@(posedge ref_clk) disable iff (!rstn) // R15
        !ctl.tckRise |=> $stable(state_ff))
        else $error("State moved without a test clock rise.");

endmodule

/* verilog/stap_top.sv */
// Boundary-scan test access port of a pipelined burst memory.
`timescale 1ns/1ps
//
// Notes on behaviour
// [R1] Paths: 3-bit IR, bypass, 32-bit ID, 107-cell chain.
// [R2] ID holds revision and part-type fields.
// [R3] ID bits 11:1 hold manufacturer code.
// [R4] ID bit 0 always reads one.
// [R5] Code 000 captures ring into chain.
// [R6] Code 001 selects identification register.
// [R7] Code 010 samples, selects chain, outputs high-Z.
// [R8] Codes 011, 101, 110 are reserved and select the bypass path.
// [R9] Code 100 samples ring, selects chain, harmless.
// [R10] Code 111 selects the one-bit bypass.
// [R11] Capture-IR loads 01 into low bits.
// [R12] Reset and Test-Logic-Reset load identification instruction.
// [R13] Cell 47 gates output bus under EXTEST.
// [R14] Sample input on rise, change output on fall.
// [R15] Sixteen-state controller; instruction takes effect in Update-IR.
module stap_top
#(
    parameter logic [stap_pkg::REV_W-1:0]  REVISION  = 3'h5,      // Arbitrary value.
    parameter logic [stap_pkg::PART_W-1:0] PART_TYPE = 17'h0_0A5C, // Arbitrary value.
    parameter logic [stap_pkg::MFR_W-1:0]  MFR_CODE  = 11'h2B7     // Arbitrary value.
)
(
    // Clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       rstn,
    // Test pins
    input  wire logic                       tck,
    input  wire logic                       tms,
    input  wire logic                       tdi,
    output logic                            tdo,
    output logic                            tdoEn,
    // Memory input/output ring
    input  wire logic [stap_pkg::BSR_W-1:0] ringIn,
    output logic      [stap_pkg::BSR_W-1:0] ringOut,
    output logic                            ringDriveEn,
    output logic                            qBusEnable
);

    // ==========================================================
    // Pin synchronisers and test clock edges
    logic                       tckMeta_ff, tckSync_ff, tckDly_ff;
    logic                       tmsMeta_ff, tmsSync_ff;
    logic                       tdiMeta_ff, tdiSync_ff;
    logic [stap_pkg::BSR_W-1:0] ringMeta_ff, ringSync_ff;
    logic                       tckRise;
    logic                       tckFall;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            tckMeta_ff  <= 1'h0;
            tckSync_ff  <= 1'h0;
            tckDly_ff   <= 1'h0;
            tmsMeta_ff  <= 1'h1;
            tmsSync_ff  <= 1'h1;
            tdiMeta_ff  <= 1'h0;
            tdiSync_ff  <= 1'h0;
            ringMeta_ff <= '0;
            ringSync_ff <= '0;
        end
        else
        begin
            tckMeta_ff  <= tck;
            tckSync_ff  <= tckMeta_ff;
            tckDly_ff   <= tckSync_ff;
            tmsMeta_ff  <= tms;
            tmsSync_ff  <= tmsMeta_ff;
            tdiMeta_ff  <= tdi;
            tdiSync_ff  <= tdiMeta_ff;
            ringMeta_ff <= ringIn;
            ringSync_ff <= ringMeta_ff;
        end
    end

    assign tckRise = tckSync_ff & ~tckDly_ff;
    assign tckFall = ~tckSync_ff & tckDly_ff;

    // ==========================================================
    // Controller
    stap_ctl_if ctl ();

    assign ctl.tckRise = tckRise;
    assign ctl.tms     = tmsSync_ff;

    stap_fsm u_fsm
    (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .ctl     (ctl)
    );

    // ==========================================================
    // State and instruction decode
    wire logic inTlr   = ctl.state == stap_pkg::ST_TLR;
    wire logic inCapIr = ctl.state == stap_pkg::ST_CAPIR;
    wire logic inShIr  = ctl.state == stap_pkg::ST_SHIR;
    wire logic inUpIr  = ctl.state == stap_pkg::ST_UPIR;
    wire logic inCapDr = ctl.state == stap_pkg::ST_CAPDR;
    wire logic inShDr  = ctl.state == stap_pkg::ST_SHDR;
    wire logic inUpDr  = ctl.state == stap_pkg::ST_UPDR;

    logic [stap_pkg::IR_W-1:0] instr_ff;
    logic [stap_pkg::IR_W-1:0] irShift_ff;

    // Reserved codes fall back to the bypass path so the chain length stays defined.
    wire logic selBsr = instr_ff == stap_pkg::INS_EXTEST  || // R5
                        instr_ff == stap_pkg::INS_SAMPLEZ || // R7
                        instr_ff == stap_pkg::INS_SAMPLE;    // R9
    wire logic selId  = instr_ff == stap_pkg::INS_IDCODE;    // R6
    wire logic selByp = !selBsr && !selId;                   // R10 R8

    wire logic [stap_pkg::ID_W-1:0] idValue = {REVISION, PART_TYPE, MFR_CODE, 1'h1}; // R2 R3 R4

    // ==========================================================
    // Instruction register
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            irShift_ff <= stap_pkg::IR_CAPTURE;
        else if (tckRise && inCapIr)
            irShift_ff <= stap_pkg::IR_CAPTURE; // R11
        else if (tckRise && inShIr)
            irShift_ff <= {tdiSync_ff, irShift_ff[stap_pkg::IR_W-1:1]}; // R1 R14
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn || inTlr)
            instr_ff <= stap_pkg::INS_IDCODE; // R12
        else if (tckFall && inUpIr)
            instr_ff <= irShift_ff; // R15
    end

    // ==========================================================
    // Data registers
    logic                       bypass_ff;
    logic [stap_pkg::ID_W-1:0]  idShift_ff;
    logic [stap_pkg::BSR_W-1:0] bsrShift_ff;
    logic [stap_pkg::BSR_W-1:0] preload_ff;
    logic [stap_pkg::BSR_W-1:0] ringCapture;

    // The internal cell has no bump, so it captures its own latched value.
    always_comb
    begin
        ringCapture                      = ringSync_ff;
        ringCapture[stap_pkg::BUS_EN_BIT] = preload_ff[stap_pkg::BUS_EN_BIT];
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            bypass_ff   <= 1'h0;
            idShift_ff  <= '0;
            bsrShift_ff <= '0;
        end
        else if (tckRise && inCapDr)
        begin
            bypass_ff  <= 1'h0; // R10
            idShift_ff <= idValue; // R6
            if (selBsr)
                bsrShift_ff <= ringCapture; // R5 R7 R9
        end
        else if (tckRise && inShDr)
        begin
            bypass_ff  <= tdiSync_ff; // R1
            idShift_ff <= {tdiSync_ff, idShift_ff[stap_pkg::ID_W-1:1]}; // R1
            if (selBsr)
                bsrShift_ff <= {tdiSync_ff, bsrShift_ff[stap_pkg::BSR_W-1:1]}; // R1
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn || inTlr)
            preload_ff <= stap_pkg::BSR_RESET; // R13
        else if (tckFall && inUpDr && selBsr)
            preload_ff <= bsrShift_ff;
    end

    // ==========================================================
    // Serial output on the falling test clock edge
    wire logic drBit = selBsr ? bsrShift_ff[0] : (selId ? idShift_ff[0] : bypass_ff);

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            tdo   <= 1'h0;
            tdoEn <= 1'h0;
        end
        else if (tckFall)
        begin
            tdo   <= inShIr ? irShift_ff[0] : drBit; // R14
            tdoEn <= inShIr || inShDr;
        end
    end

    // ==========================================================
    // Ring and output bus control
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            ringOut     <= '0;
            ringDriveEn <= 1'h0;
            qBusEnable  <= 1'h1;
        end
        else
        begin
            ringOut     <= preload_ff;
            ringDriveEn <= instr_ff == stap_pkg::INS_EXTEST;
            if (instr_ff == stap_pkg::INS_EXTEST)
                qBusEnable <= preload_ff[stap_pkg::BUS_EN_BIT]; // R13
            else
                qBusEnable <= instr_ff != stap_pkg::INS_SAMPLEZ; // R7
        end
    end

    // ==========================================================
    // Checks
    sequence capIrEdge;
        inCapIr && tckRise;
    endsequence

    sequence idCaptureEdge;
        selId && inCapDr && tckRise;
    endsequence

    chk_ir_capture_pat: assert property (@(posedge ref_clk) disable iff (!rstn) // R11
        capIrEdge |=> irShift_ff[1:0] == 2'h1)
        else $error("Capture-IR pattern not loaded.");

    chk_ir_shift_in: assert property (@(posedge ref_clk) disable iff (!rstn) // R1
        inShIr && tckRise
        |=> irShift_ff[2] == $past(tdiSync_ff) && irShift_ff[1] == $past(irShift_ff[2]))
        else $error("Instruction shift path wrong.");

    chk_reset_idcode: assert property (@(posedge ref_clk) disable iff (!rstn) // R12
        inTlr |=> instr_ff == stap_pkg::INS_IDCODE && preload_ff[stap_pkg::BUS_EN_BIT])
        else $error("Test reset did not restore instruction or cell 47.");

    chk_update_ir_load: assert property (@(posedge ref_clk) disable iff (!rstn) // R15
        inUpIr && tckFall |=> instr_ff == $past(irShift_ff))
        else $error("Update-IR did not load the instruction.");

    chk_id_capture_val: assert property (@(posedge ref_clk) disable iff (!rstn) // R4
        idCaptureEdge |=> idShift_ff == idValue && idShift_ff[0])
        else $error("Identification capture wrong.");

    chk_bypass_capture: assert property (@(posedge ref_clk) disable iff (!rstn) // R10
        selByp && inCapDr && tckRise |=> !bypass_ff)
        else $error("Bypass cell not cleared on capture.");

    chk_extest_bus_en: assert property (@(posedge ref_clk) disable iff (!rstn) // R13
        instr_ff == stap_pkg::INS_EXTEST |=> qBusEnable == $past(preload_ff[stap_pkg::BUS_EN_BIT]))
        else $error("Cell 47 does not steer the output bus.");

    chk_samplez_hiz: assert property (@(posedge ref_clk) disable iff (!rstn) // R7
        instr_ff == stap_pkg::INS_SAMPLEZ |=> !qBusEnable)
        else $error("Output bus not released under high-Z sample.");

    chk_tdo_on_fall: assert property (@(posedge ref_clk) disable iff (!rstn) // R14
        $changed(tdo) |-> $past(tckFall))
        else $error("Serial output changed off a falling edge.");

endmodule

/* verif/stap_jtag_ctl.sv */
// Behavioural board-level scan controller driving the test pins.
`timescale 1ns/1ps
module stap_jtag_ctl
(
    // Clock
    input  wire logic ref_clk,
    // Test pins
    input  wire logic tdo,
    input  wire logic tdoEn,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    logic enSeen;

    initial
    begin
        tck <= 1'b0;
        tms <= 1'b1;
        tdi <= 1'b0;
        enSeen = 1'b0;
    end

    // ==========================================================
    // One test clock period of 160 ns; the clock stands low between calls.
    task automatic tick(input logic m, input logic d, output logic q, output logic qLate);
        @(posedge ref_clk);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge ref_clk);
        q = tdo;
        enSeen = tdoEn;
        tck <= 1'b1;
        repeat (8) @(posedge ref_clk);
        qLate = tdo;
        tck <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    // ==========================================================
    // Full scan from Run-Test/Idle back to Run-Test/Idle, least significant bit first.
    // Only defined instruction codes are ever handed in here.
    task automatic scan(input logic ir, input logic [127:0] din, input int n,
                        output logic [127:0] dout, output logic moved, output logic enOk);
        logic q;
        logic ql;
        moved = 1'b0;
        enOk = 1'b1;
        dout = '0;
        tick(1'b1, ~tdi, q, ql);
        if (ir)
        begin
            tick(1'b1, ~tdi, q, ql);
        end
        tick(1'b0, ~tdi, q, ql);
        tick(1'b0, ~tdi, q, ql);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], q, ql);
            dout[i] = q;
            moved = moved | (q !== ql);
            enOk = enOk & (enSeen === 1'b1);
        end
        tick(1'b1, ~tdi, q, ql);
        tick(1'b0, ~tdi, q, ql);
    endtask
endmodule

/* verif/tb_top.sv */
// Self-checking bench of the memory test access port.
`timescale 1ns/1ps
module tb_top;
    // Arbitrary identification values.
    localparam logic [2:0]   REV  = 3'h6;
    localparam logic [16:0]  PART = 17'h1_2345;
    localparam logic [10:0]  MFR  = 11'h155;
    localparam logic [106:0] PA   = 107'h5_3C_9ABC_DEF0_1234_5678_0FED_CBA9;
    localparam logic [106:0] PB   = ~PA;

    logic         ref_clk;
    logic         rstn;
    logic         tck;
    logic         tms;
    logic         tdi;
    logic         tdo;
    logic         tdoEn;
    logic [106:0] ringIn;
    logic [106:0] ringOut;
    logic         ringDriveEn;
    logic         qBusEnable;
    logic [106:0] expV;
    logic [127:0] d;
    int           failCount = 0;
    int           checks = 0;
    int           cycles = 0;

    stap_top #(.REVISION(REV), .PART_TYPE(PART), .MFR_CODE(MFR)) stap_top_i
    (
        .ref_clk(ref_clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoEn(tdoEn), .ringIn(ringIn), .ringOut(ringOut), .ringDriveEn(ringDriveEn),
        .qBusEnable(qBusEnable)
    );

    stap_jtag_ctl stap_jtag_ctl_i
    (
        .ref_clk(ref_clk), .tdo(tdo), .tdoEn(tdoEn), .tck(tck), .tms(tms), .tdi(tdi)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // Checking and closing
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failCount++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (failCount == 0 && checks > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            failCount++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            results();
        end
    end

    // ==========================================================
    // Scan access tasks
    task automatic drScan(input logic [127:0] din, input int n, output logic [127:0] dout);
        logic mv;
        logic en;
        stap_jtag_ctl_i.scan(1'b0, din, n, dout, mv, en);
        check(128'({mv, en}), 128'h1);
    endtask

    task automatic irLoad(input logic [2:0] code);
        logic [127:0] dd;
        logic         mv;
        logic         en;
        stap_jtag_ctl_i.scan(1'b1, 128'(code), 3, dd, mv, en);
        check(128'(dd[1:0]), 128'h1);
        check(128'({mv, en}), 128'h1);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        logic q;
        logic ql;
        rstn <= 1'b0;
        ringIn <= '0;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check(128'({qBusEnable, ringDriveEn, tdoEn, tdo}), 128'h8);
        stap_jtag_ctl_i.tick(1'b0, 1'b0, q, ql);
        drScan('0, 32, d);
        check(128'(d[31:0]), 128'({REV, PART, MFR, 1'b1}));
        irLoad(stap_pkg::INS_BYPASS);
        drScan(128'h1, 2, d);
        check(128'(d[1:0]), 128'h2);
        ringIn <= PA;
        irLoad(stap_pkg::INS_SAMPLE);
        check(128'({qBusEnable, ringDriveEn}), 128'h2);
        expV = PA;
        expV[47] = 1'b1;
        drScan(128'(PB), 107, d);
        check(128'(d[106:0]), 128'(expV));
        check(128'(ringOut), 128'(PB));
        irLoad(stap_pkg::INS_SAMPLEZ);
        check(128'(qBusEnable), 128'h0);
        ringIn <= PB;
        drScan(128'(PA), 107, d);
        check(128'(d[106:0]), 128'(PB));
        irLoad(stap_pkg::INS_EXTEST);
        check(128'({qBusEnable, ringDriveEn}), 128'h1);
        expV = PB;
        expV[47] = 1'b0;
        drScan(128'(PB), 107, d);
        check(128'(d[106:0]), 128'(expV));
        check(128'({qBusEnable, ringDriveEn}), 128'h3);
        check(128'(ringOut), 128'(PB));
        irLoad(stap_pkg::INS_IDCODE);
        check(128'({qBusEnable, ringDriveEn}), 128'h2);
        drScan('0, 32, d);
        check(128'(d[31:0]), 128'({REV, PART, MFR, 1'b1}));
        irLoad(stap_pkg::INS_EXTEST);
        drScan(128'(PA), 107, d);
        check(128'(d[106:0]), 128'(PB));
        check(128'({qBusEnable, ringDriveEn}), 128'h1);
        repeat (5) stap_jtag_ctl_i.tick(1'b1, 1'b0, q, ql);
        stap_jtag_ctl_i.tick(1'b0, 1'b0, q, ql);
        check(128'({qBusEnable, ringDriveEn}), 128'h2);
        drScan('0, 32, d);
        check(128'(d[31:0]), 128'({REV, PART, MFR, 1'b1}));
        irLoad(stap_pkg::INS_EXTEST);
        check(128'({qBusEnable, ringDriveEn}), 128'h3);
        check(128'(ringOut), 128'(stap_pkg::BSR_RESET));
        results();
    end
endmodule
